// File: bench/testbench.sv
// Purpose: Self-checking bench for the lane mapper and its receiver model.
// Assumes: Inputs change on the falling edge; lanes answer one edge after a sample.
// Notes:   One pattern vector feeds every sample input and is rotated per sample.
`timescale 1ns/1ps
module testbench;
    logic [435:0] pat;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic [6:0]   mode = 7'h00;
    logic         shm = 1'b0;
    logic         sv = 1'b0;
    logic [255:0] g1;
    logic [255:0] g2;
    logic [7:0]   en;
    logic         lv, crc, fec, sup;
    logic [31:0]  rx1, rx2;
    int           n_mismatch = 0;
    int           n_tests = 0;
    int           cyc = 0;
    logic [6:0]   m4 [5] = '{7'h18, 7'h3d, 7'h40, 7'h45, 7'h47};
    logic [6:0]   m16s [5] = '{7'h19, 7'h30, 7'h3e, 7'h41, 7'h46};
    logic [6:0]   m16 [3] = '{7'h1b, 7'h36, 7'h3f};
    wire  [119:0] iw = pat[119:0];
    wire  [119:0] qw = pat[239:120];
    wire  [95:0]  rs = pat[335:240];
    wire  [47:0]  rb = pat[383:336];
    wire  [15:0]  bi = pat[399:384];
    wire  [15:0]  bq = pat[415:400];
    wire  [7:0]   ior = pat[423:416];
    wire  [7:0]   qor = pat[431:424];
    wire  [3:0]   ors = pat[435:432];
    tlm_mapper uut (.clk(clk), .rst(rst), .link_mode_select(mode), .sync_header_mode(shm),
        .sample_valid(sv), .first_chan_inphase_word(iw), .first_chan_quad_word(qw),
        .inphase_overrange_flag(ior), .quadrature_overrange_flag(qor),
        .second_chan_inphase_word(bi), .second_chan_quad_word(bq),
        .first_chan_inphase_overrange(ors[0]), .first_chan_quad_overrange(ors[1]),
        .second_chan_inphase_overrange(ors[2]), .second_chan_quad_overrange(ors[3]),
        .raw_sample(rs), .raw_second_chan(rb), .first_group_lane(g1), .second_group_lane(g2),
        .lane_enable(en), .lane_valid(lv), .crc12_enable(crc), .fec_enable(fec),
        .mode_supported(sup));
    tlm_rx_model u_rx (.clk(clk), .rst(rst), .first_group_lane(g1), .second_group_lane(g2),
        .lane_valid(lv), .rx_first_ff(rx1), .rx_second_ff(rx2));
    // Clock and a hang guard; a full run needs well under two thousand cycles.
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask : chk
    // Mode settles one cycle ahead of the sample; the check point is the valid cycle.
    task automatic send(input logic [6:0] m);
        @(negedge clk) mode = m;
        pat = {pat[428:0], pat[435:429]};
        @(negedge clk) sv = 1'b1;
        @(negedge clk) sv = 1'b0;
    endtask : send
    task automatic t_dec(input logic [6:0] m, input logic [7:0] e, input bit sh);
        send(m);
        chk("valid", 32'h1, 32'(lv));
        chk("enable", 32'(e), 32'(en));
        for (int k = 0; k < 8; k++) begin
            if (e[k]) begin
                chk("grp1", 32'({iw[15*k+:15], ior[sh ? k/2 : k]}), 32'(g1[32*k+16+:16]));
                chk("grp2", 32'({qw[15*k+:15], qor[sh ? k/2 : k]}), 32'(g2[32*k+16+:16]));
            end
        end
    endtask : t_dec
    task automatic t_byp(input logic [6:0] m, input bit dual);
        logic [47:0] ea;
        logic [47:0] eb;
        send(m);
        ea = dual ? {rs[11:0], rs[23:12], rs[35:24], rs[47:36]}
                  : {rs[11:0], rs[35:24], rs[59:48], rs[83:72]};
        eb = dual ? {rb[11:0], rb[23:12], rb[35:24], rb[47:36]}
                  : {rs[23:12], rs[47:36], rs[71:60], rs[95:84]};
        chk("enable", 32'h7, 32'(en));
        for (int k = 0; k < 3; k++) begin
            chk("grp1", 32'(ea[47-16*k-:16]), 32'(g1[32*k+16+:16]));
            chk("grp2", 32'(eb[47-16*k-:16]), 32'(g2[32*k+16+:16]));
        end
    endtask : t_byp
    task automatic t_dual(input logic [6:0] m);
        send(m);
        if (m == 7'h25) begin
            chk("ai", 32'({iw[14:0], ors[0]}), 32'(g1[31:16]));
            chk("bq", 32'({bq[14:0], ors[3]}), 32'(g2[63:48]));
        end else begin
            chk("grp1", {iw[14:0], ors[0], qw[14:0], ors[1]}, g1[31:0]);
            chk("grp2", {bi[14:0], ors[2], bq[14:0], ors[3]}, g2[31:0]);
            @(negedge clk);
            chk("rx", {bi[14:0], ors[2], bq[14:0], ors[3]}, rx2);
        end
    endtask : t_dual
    initial begin
        for (int i = 0; i < 436; i++) pat[i] = ((i * 37) % 11) > 4;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        foreach (m4[i]) t_dec(m4[i], 8'h03, 1'b0);
        foreach (m16s[i]) t_dec(m16s[i], 8'hff, 1'b1);
        t_dec(7'h1a, 8'h0f, 1'b0);
        t_dec(7'h34, 8'h0f, 1'b0);
        foreach (m16[i]) t_dec(m16[i], 8'hff, 1'b0);
        t_dec(7'h26, 8'h01, 1'b0);
        t_byp(7'h20, 1'b0);
        t_byp(7'h21, 1'b1);
        send(7'h23);
        for (int k = 0; k < 2; k++)
            chk("oct", 32'({rs[12*k+4+:8], rb[12*k+4+:8]}), 32'({g1[32*k+24+:8], g2[32*k+24+:8]}));
        t_dual(7'h25);
        t_dual(7'h27);
        t_dual(7'h38);
        for (int h = 0; h < 2; h++) begin
            @(negedge clk) shm = h[0];
            @(negedge clk) chk("sync", 32'({~h[0], h[0]}), 32'({crc, fec}));
        end
        send(7'h7f);
        chk("refuse", 32'h0, {g1[28:0], lv, en[0], sup});
        tally_and_finish();
    end
endmodule : testbench

// File: bench/tlm_mapper_assertions.sv
// Purpose: Concurrent checks on the lane mapper ports.
// Assumes: One clock, asynchronous active-high reset.
// Notes:   Mode-keyed checks use the mode seen one edge earlier, as lanes are registered.
`timescale 1ns/1ps
`include "tlm_defines.svh"
module tlm_mapper_assertions (
    input wire logic                               clk,
    input wire logic                               rst,
    input wire logic [`TLM_MODE_W-1:0]             link_mode_select,
    input wire logic                               sync_header_mode,
    input wire logic                               sample_valid,
    input wire logic [8*15-1:0]                    first_chan_inphase_word,
    input wire logic [8*15-1:0]                    first_chan_quad_word,
    input wire logic [7:0]                         quadrature_overrange_flag,
    input wire logic                               first_chan_quad_overrange,
    input wire logic [`TLM_LANES*`TLM_LANE_W-1:0]  first_group_lane,
    input wire logic [`TLM_LANES*`TLM_LANE_W-1:0]  second_group_lane,
    input wire logic [`TLM_LANES-1:0]              lane_enable,
    input wire logic                               lane_valid,
    input wire logic                               crc12_enable,
    input wire logic                               fec_enable,
    input wire logic                               mode_supported
);
    // All checks share the one clock, and reset voids them while it is held.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_SH_ONE_OF_TWO: assert property (crc12_enable != fec_enable)
        else $error("sync header selection is not exactly one mode");
    AST_SH_CRC: assert property (!$past(rst) && !$past(sync_header_mode) |-> crc12_enable)
        else $error("checking mode selected but cyclic check is off");
    AST_SH_FEC: assert property (!$past(rst) && $past(sync_header_mode) |-> fec_enable)
        else $error("correction mode selected but correction is off");
    AST_VALID_CAUSE: assert property (lane_valid |-> $past(sample_valid) && mode_supported)
        else $error("lane data flagged valid without a sample or mode");
    AST_REFUSED_QUIET: assert property (!mode_supported |-> !lane_valid && lane_enable == 8'h00)
        else $error("unsupported mode still drives lanes");
    AST_EN_M24: assert property (!$past(rst) && $past(link_mode_select) == 7'h18 |-> lane_enable == 8'h03)
        else $error("four-lane mode enables wrong lanes");
    AST_EN_M25: assert property (!$past(rst) && $past(link_mode_select) == 7'h19 |-> lane_enable == 8'hff)
        else $error("sixteen-lane mode enables wrong lanes");
    AST_EN_M26: assert property (!$past(rst) && $past(link_mode_select) == 7'h1a |-> lane_enable == 8'h0f)
        else $error("eight-lane mode enables wrong lanes");
    AST_EN_M38: assert property (!$past(rst) && $past(link_mode_select) == 7'h26 |-> lane_enable == 8'h01)
        else $error("two-lane mode enables wrong lanes");
    AST_D4_QUAD: assert property (lane_valid && $past(link_mode_select) == 7'h25 |-> first_group_lane[63:48]
        == {$past(first_chan_quad_word[14:0]), $past(first_chan_quad_overrange)})
        else $error("dual quadrature word misplaced");
    AST_S8_Q1: assert property (lane_valid && $past(link_mode_select) == 7'h18 |-> second_group_lane[63:48]
        == {$past(first_chan_quad_word[29:15]), $past(quadrature_overrange_flag[1])})
        else $error("quadrature word one misplaced");
    COV_DUAL_TWO_LANE: cover property (lane_valid && link_mode_select == 7'h27);
    COV_FEC: cover property (fec_enable);
    COV_REFUSE: cover property (!mode_supported && $past(mode_supported));
endmodule : tlm_mapper_assertions

bind tlm_mapper tlm_mapper_assertions u_chk (.clk(clk), .rst(rst),
    .link_mode_select(link_mode_select), .sync_header_mode(sync_header_mode),
    .sample_valid(sample_valid), .first_chan_inphase_word(first_chan_inphase_word),
    .first_chan_quad_word(first_chan_quad_word),
    .quadrature_overrange_flag(quadrature_overrange_flag),
    .first_chan_quad_overrange(first_chan_quad_overrange),
    .first_group_lane(first_group_lane), .second_group_lane(second_group_lane),
    .lane_enable(lane_enable), .lane_valid(lane_valid), .crc12_enable(crc12_enable),
    .fec_enable(fec_enable), .mode_supported(mode_supported));

// File: bench/tlm_rx_model.sv
// Purpose: Receiver side that unpacks lane zero of both groups.
// Assumes: Link mode is agreed with the mapper before traffic starts.
// Notes:   Holds the last captured slices; no link error handling is modelled.
`timescale 1ns/1ps
`include "tlm_defines.svh"
module tlm_rx_model (
    input  wire logic                               clk,
    input  wire logic                               rst,
    input  wire logic [`TLM_LANES*`TLM_LANE_W-1:0]  first_group_lane,
    input  wire logic [`TLM_LANES*`TLM_LANE_W-1:0]  second_group_lane,
    input  wire logic                               lane_valid,
    output logic      [31:0]                        rx_first_ff,
    output logic      [31:0]                        rx_second_ff
);
    // Capture only on valid beats, since idle lanes would hand the user stale words.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_first_ff  <= 32'h0000_0000;
            rx_second_ff <= 32'h0000_0000;
        end else if (lane_valid) begin
            rx_first_ff  <= first_group_lane[31:0];
            rx_second_ff <= second_group_lane[31:0];
        end
    end
endmodule : tlm_rx_model

// File: pkg/tlm_defines.svh
// Purpose: Constants for the transport lane mapper and sync header selector.
// Assumes: 20 MHz clock, one lane word per clock per lane.
// Notes:   Link mode numbers are the values carried on link_mode_select.
`ifndef TLM_DEFINES_SVH
`define TLM_DEFINES_SVH
`define TLM_LANES        8
`define TLM_LANE_W       32
`define TLM_MODE_W       7
`define TLM_OR_POS       0
`define TLM_SAMPLE_LSB   1
`define TLM_HDR_CRC12    1'b0
`define TLM_HDR_FEC      1'b1
`define TLM_RST_LANE     32'h0000_0000
`endif

// File: pkg/tlm_pkg.sv
// Purpose: Types for the transport lane mapper.
// Assumes: Constants come from tlm_defines.svh.
// Notes:   Placement classes group link modes that share a lane layout.
package tlm_pkg;
    typedef enum logic [3:0] {
        TLM_PL_NONE,
        TLM_PL_S8_2,
        TLM_PL_S8_4,
        TLM_PL_S8_8,
        TLM_PL_S8_16,
        TLM_PL_S4_16,
        TLM_PL_BYP_S,
        TLM_PL_BYP_D,
        TLM_PL_OCT_D,
        TLM_PL_D4_4,
        TLM_PL_D8_2
    } tlm_place_e;
    typedef enum logic {
        TLM_SH_CRC12,
        TLM_SH_FEC
    } tlm_sh_e;
endpackage : tlm_pkg

// File: rtl/tlm_mapper.sv
// Purpose: Maps converter samples onto two groups of lanes per link mode.
// Assumes: Samples are on the same clock; link mode is static while the link runs.
// Notes:   Each lane output is one 32-bit multiframe slice per clock, octet 0 in bits 31:24.
`timescale 1ns/1ps
`include "tlm_defines.svh"
module tlm_mapper (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic [`TLM_MODE_W-1:0]     link_mode_select,
    input  wire logic                       sync_header_mode,
    input  wire logic                       sample_valid,
    input  wire logic [8*15-1:0]            first_chan_inphase_word,
    input  wire logic [8*15-1:0]            first_chan_quad_word,
    input  wire logic [7:0]                 inphase_overrange_flag,
    input  wire logic [7:0]                 quadrature_overrange_flag,
    input  wire logic [15:0]                second_chan_inphase_word,
    input  wire logic [15:0]                second_chan_quad_word,
    input  wire logic                       first_chan_inphase_overrange,
    input  wire logic                       first_chan_quad_overrange,
    input  wire logic                       second_chan_inphase_overrange,
    input  wire logic                       second_chan_quad_overrange,
    input  wire logic [8*12-1:0]            raw_sample,
    input  wire logic [4*12-1:0]            raw_second_chan,
    output logic [`TLM_LANES*`TLM_LANE_W-1:0] first_group_lane,
    output logic [`TLM_LANES*`TLM_LANE_W-1:0] second_group_lane,
    output logic [`TLM_LANES-1:0]           lane_enable,
    output logic                            lane_valid,
    output logic                            crc12_enable,
    output logic                            fec_enable,
    output logic                            mode_supported
);

    // Decodes a link mode number into its lane placement class.
    function automatic tlm_pkg::tlm_place_e place_of(input logic [`TLM_MODE_W-1:0] m);
        case (m)
            7'd23, 7'd38: place_of = tlm_pkg::TLM_PL_S8_2;
            7'd24, 7'd61, 7'd64, 7'd69, 7'd71: place_of = tlm_pkg::TLM_PL_S8_4;
            7'd26, 7'd52: place_of = tlm_pkg::TLM_PL_S8_8;
            7'd27, 7'd54, 7'd63: place_of = tlm_pkg::TLM_PL_S8_16;
            7'd25, 7'd48, 7'd62, 7'd65, 7'd70: place_of = tlm_pkg::TLM_PL_S4_16;
            7'd32: place_of = tlm_pkg::TLM_PL_BYP_S;
            7'd33: place_of = tlm_pkg::TLM_PL_BYP_D;
            7'd35: place_of = tlm_pkg::TLM_PL_OCT_D;
            7'd37: place_of = tlm_pkg::TLM_PL_D4_4;
            7'd39, 7'd56: place_of = tlm_pkg::TLM_PL_D8_2;
            default: place_of = tlm_pkg::TLM_PL_NONE;
        endcase
    endfunction : place_of

    // Builds a 16-bit lane word from a 15-bit sample and its overrange bit.
    function automatic logic [15:0] lane_word(input logic [14:0] s, input logic o);
        lane_word = {s, o};
    endfunction : lane_word

    // Packs four 12-bit samples into three 16-bit lanes, most significant nibble first.
    function automatic logic [47:0] pack12(input logic [47:0] s4);
        pack12 = s4;
    endfunction : pack12

    // Lane map summary, one line per placement class. Group one is the first
    // eight lanes and group two the second eight. Each lane slice is 32 bits.
    // Octet 0 sits in bits 31:24 and octet 3 in bits 7:0.
    //
    // Two-lane single decimate-by-8: I0 on group-one lane 0, Q0 on group-two lane 0.
    // Four-lane single decimate-by-8: I0, I1 and Q0, Q1 on lanes 0 and 1.
    // Eight-lane single decimate-by-8: I0 to I3 and Q0 to Q3 on lanes 0 to 3.
    // Sixteen-lane single decimate-by-8: I0 to I7 and Q0 to Q7 on lanes 0 to 7.
    // Sixteen-lane single decimate-by-4: as above, but lane pairs share a flag.
    // Single bypass: even samples on group one, odd samples on group two.
    // Dual bypass: channel A on group one, channel B on group two.
    // Dual 8-bit: one octet per lane in octet 0, channels split by group.
    // Dual decimate-by-4: I on lane 0 and Q on lane 1 of each group.
    // Dual two-lane modes: I in octets 0-1 and Q in octets 2-3 of lane 0.
    //
    // Unused lanes and unused octets are driven to zero. A receiver that
    // ignores lane_enable then sees a clean zero rather than stale data.
    // The link mode is decoded combinationally every cycle. A change of mode
    // therefore takes effect at the very next registered sample. The link
    // layer must hold the mode steady while a link is up, because half a
    // multiframe in one layout and half in another cannot be unpacked.
    //
    // Trade-off: every layout is computed in parallel and one is selected.
    // This costs area but keeps the latency at exactly one clock for all
    // modes, so the receiver never has to account for a mode-dependent delay.
    tlm_pkg::tlm_place_e                     place;
    logic [`TLM_LANES*`TLM_LANE_W-1:0]       nxt_first;
    logic [`TLM_LANES*`TLM_LANE_W-1:0]       nxt_second;
    logic [`TLM_LANES-1:0]                   nxt_enable;
    logic [47:0]                             even_pack;
    logic [47:0]                             odd_pack;
    logic [47:0]                             a_pack;
    logic [47:0]                             b_pack;
    logic [15:0]                             iw [0:7];
    logic [15:0]                             qw [0:7];
    logic [15:0]                             iw_pair [0:7];
    logic [15:0]                             qw_pair [0:7];

    assign place = place_of(link_mode_select);

    // Per-lane words for the decimated placements, including pair-shared overrange.
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_words
            assign iw[g] = lane_word(first_chan_inphase_word[g*15 +: 15],
                                     inphase_overrange_flag[g]);
            assign qw[g] = lane_word(first_chan_quad_word[g*15 +: 15],
                                     quadrature_overrange_flag[g]);
            assign iw_pair[g] = lane_word(first_chan_inphase_word[g*15 +: 15],
                                          inphase_overrange_flag[g/2]);
            assign qw_pair[g] = lane_word(first_chan_quad_word[g*15 +: 15],
                                          quadrature_overrange_flag[g/2]);
        end
    endgenerate

    // Gather even, odd, first-channel and second-channel raw samples for nibble packing.
    // Dual bypass takes channel A as raw samples 0 to 3 in order. Single bypass splits
    // even and odd samples instead. Sharing one packer for both would put the
    // wrong samples on group one.
    always_comb begin
        a_pack    = pack12({raw_sample[0*12 +: 12], raw_sample[1*12 +: 12],
                            raw_sample[2*12 +: 12], raw_sample[3*12 +: 12]});
        even_pack = pack12({raw_sample[0*12 +: 12], raw_sample[2*12 +: 12],
                            raw_sample[4*12 +: 12], raw_sample[6*12 +: 12]});
        odd_pack  = pack12({raw_sample[1*12 +: 12], raw_sample[3*12 +: 12],
                            raw_sample[5*12 +: 12], raw_sample[7*12 +: 12]});
        b_pack    = pack12({raw_second_chan[0*12 +: 12], raw_second_chan[1*12 +: 12],
                            raw_second_chan[2*12 +: 12], raw_second_chan[3*12 +: 12]});
    end

    // Lane placement per class; 16-bit words sit in octets 0-1 of each lane,
    // octets 2-3 are used only by the four-octet dual layouts.
    always_comb begin
        nxt_first  = '0;
        nxt_second = '0;
        nxt_enable = '0;
        case (place)
            tlm_pkg::TLM_PL_S8_2: begin
                nxt_first[31:16]  = iw[0];
                nxt_second[31:16] = qw[0];
                nxt_enable        = 8'h01;
            end
            tlm_pkg::TLM_PL_S8_4: begin
                for (int k = 0; k < 2; k++) begin
                    nxt_first[k*32+16 +: 16]  = iw[k];
                    nxt_second[k*32+16 +: 16] = qw[k];
                end
                nxt_enable = 8'h03;
            end
            tlm_pkg::TLM_PL_S8_8: begin
                for (int k = 0; k < 4; k++) begin
                    nxt_first[k*32+16 +: 16]  = iw[k];
                    nxt_second[k*32+16 +: 16] = qw[k];
                end
                nxt_enable = 8'h0f;
            end
            tlm_pkg::TLM_PL_S8_16: begin
                for (int k = 0; k < 8; k++) begin
                    nxt_first[k*32+16 +: 16]  = iw[k];
                    nxt_second[k*32+16 +: 16] = qw[k];
                end
                nxt_enable = 8'hff;
            end
            tlm_pkg::TLM_PL_S4_16: begin
                for (int k = 0; k < 8; k++) begin
                    nxt_first[k*32+16 +: 16]  = iw_pair[k];
                    nxt_second[k*32+16 +: 16] = qw_pair[k];
                end
                nxt_enable = 8'hff;
            end
            tlm_pkg::TLM_PL_BYP_S: begin
                for (int k = 0; k < 3; k++) begin
                    nxt_first[k*32+16 +: 16]  = even_pack[47-k*16 -: 16];
                    nxt_second[k*32+16 +: 16] = odd_pack[47-k*16 -: 16];
                end
                nxt_enable = 8'h07;
            end
            tlm_pkg::TLM_PL_BYP_D: begin
                for (int k = 0; k < 3; k++) begin
                    nxt_first[k*32+16 +: 16]  = a_pack[47-k*16 -: 16];
                    nxt_second[k*32+16 +: 16] = b_pack[47-k*16 -: 16];
                end
                nxt_enable = 8'h07;
            end
            tlm_pkg::TLM_PL_OCT_D: begin
                // Channel A 8-bit samples are raw samples 0 and 1, upper 8 bits.
                nxt_first[31:24]  = raw_sample[0*12+4 +: 8];
                nxt_first[63:56]  = raw_sample[1*12+4 +: 8];
                nxt_second[31:24] = raw_second_chan[0*12+4 +: 8];
                nxt_second[63:56] = raw_second_chan[1*12+4 +: 8];
                nxt_enable        = 8'h03;
            end
            tlm_pkg::TLM_PL_D4_4: begin
                nxt_first[31:16]  = lane_word(first_chan_inphase_word[14:0],
                                              first_chan_inphase_overrange);
                nxt_first[63:48]  = lane_word(first_chan_quad_word[14:0],
                                              first_chan_quad_overrange);
                nxt_second[31:16] = lane_word(second_chan_inphase_word[14:0],
                                              second_chan_inphase_overrange);
                nxt_second[63:48] = lane_word(second_chan_quad_word[14:0],
                                              second_chan_quad_overrange);
                nxt_enable        = 8'h03;
            end
            tlm_pkg::TLM_PL_D8_2: begin
                nxt_first[31:0]  = {lane_word(first_chan_inphase_word[14:0],
                                              first_chan_inphase_overrange),
                                    lane_word(first_chan_quad_word[14:0],
                                              first_chan_quad_overrange)};
                nxt_second[31:0] = {lane_word(second_chan_inphase_word[14:0],
                                              second_chan_inphase_overrange),
                                    lane_word(second_chan_quad_word[14:0],
                                              second_chan_quad_overrange)};
                nxt_enable       = 8'h01;
            end
            default: begin
                nxt_enable = 8'h00;
            end
        endcase
    end

    // Lane data registers; they hold their value while no new sample arrives.
    // Holding avoids needless toggling on the serializer inputs between samples.
    // The hold is only safe because lane_valid marks each fresh word.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            first_group_lane  <= '0;
            second_group_lane <= '0;
        end else if (sample_valid) begin
            first_group_lane  <= nxt_first;
            second_group_lane <= nxt_second;
        end
    end

    // Lane enables and valid follow the mode; unsupported modes disable every lane.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lane_enable    <= '0;
            lane_valid     <= 1'b0;
            mode_supported <= 1'b0;
        end else begin
            lane_enable    <= nxt_enable;
            lane_valid     <= sample_valid && (place != tlm_pkg::TLM_PL_NONE);
            mode_supported <= (place != tlm_pkg::TLM_PL_NONE);
        end
    end

    // The two enables are registered so the link layer sees a clean level.
    // They leave reset in checking mode, which is the safer default because
    // a receiver that expects correction still detects errors through it.
    // Sync header selection: only CRC-12 or FEC exist, so one bit fully decides
    // and no encoding can ever request the 3-bit check.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            crc12_enable <= 1'b1;
            fec_enable   <= 1'b0;
        end else begin
            crc12_enable <= (sync_header_mode == `TLM_HDR_CRC12);
            fec_enable   <= (sync_header_mode == `TLM_HDR_FEC);
        end
    end

endmodule : tlm_mapper
